// [logic/rsf_pkg.sv]
// Constants, register map and carrier types of the return stack and fast context block.
// Assumes one 250 MHz core clock, an APB master for software and same-clock decode logic.
// Behaviour
// - Push advances pointer, then stores program counter.
// - Pop decrements pointer, discarding the top entry.
// - Top entry byte registers are readable and writable.
// - Bit 7 flags stack full or overflowed.
// - Bit 6 flags stack underflow occurred.
// - Pointer bits 4-0 read/write, bit 5 zero.
// - Fault flags only cleared; zero at power-on.
// - Fault with reset enable sets flag, then resets.
// - Fault without reset enable only sets flag.
// - One hidden shadow for status, working, bank.
// - Interrupt vectoring loads all three shadows.
// - Fast interrupt return restores the three registers.
// - Nested interrupt overwrites shadows; no second level.
// - Fast call saves, fast return restores shadows.
// - Core clock divided into four phases.
// - Counter increments phase one; latch in phase four.
// - Fetch and execute overlap by one instruction cycle.
// - Operand read phase two, destination write phase four.
// - Program counter change flushes the next instruction.
// - Thirty-one entries of twenty-one bits, own storage.
// - Pointer zero after reset; slot zero has no storage.
// - Without fault reset, pointer stays at 31.
// - Pop at zero returns zero, sets underflow.
package rsf_pkg;

  localparam int RSF_PC_W   = 21;  // Return address width
  localparam int RSF_PTR_W  = 5;   // Stack pointer width
  localparam int RSF_DEPTH  = 31;  // Entries with storage behind them
  localparam int RSF_PHASES = 4;   // Phases per instruction cycle

  // Register byte offsets on APB
  localparam logic [7:0] RSF_OFS_PTR  = 8'h00;
  localparam logic [7:0] RSF_OFS_TOP_ENTRY_LOW_BYTE = 8'h04;
  localparam logic [7:0] RSF_OFS_TOP_ENTRY_HIGH_BYTE = 8'h08;
  localparam logic [7:0] RSF_OFS_TOP_ENTRY_UPPER_BYTE = 8'h0C;
  localparam logic [7:0] RSF_OFS_CTRL = 8'h10;

  // Field positions
  localparam int RSF_FULL_BIT = 7;
  localparam int RSF_UNF_BIT  = 6;
  localparam int RSF_FRE_BIT  = 0;

  // Values after reset, and the stack pointer value when full
  localparam logic [4:0] RSF_PTR_RST  = 5'h00;
  localparam logic [4:0] RSF_PTR_TOP  = 5'h1F;
  localparam logic       RSF_FRE_RST  = 1'h1;
  localparam logic [1:0] RSF_QCNT_RST = 2'h3;

  typedef enum logic {RSF_APB_IDLE, RSF_APB_ANSWER} rsf_apb_st_t;

  // Live or saved fast context
  typedef struct packed {
    logic [7:0] status;
    logic [7:0] working_register;
    logic [3:0] bank_select_register;
  } rsf_ctx_t;

  // One-cycle requests from decode and execute
  typedef struct packed {
    logic                push;
    logic                pop_ret;
    logic                pop_drop;
    logic [RSF_PC_W-1:0] program_counter;
    logic                fast_save;
    logic                fast_restore;
    logic                pc_change;
    rsf_ctx_t            live;
  } rsf_cmd_t;

  // Answers to decode and execute
  typedef struct packed {
    logic                ret_valid;
    logic [RSF_PC_W-1:0] ret_pc;
    logic                ctx_valid;
    rsf_ctx_t            ctx;
    logic                fault_reset;
  } rsf_rsp_t;

  // Phase sequencer outputs
  typedef struct packed {
    logic [RSF_PHASES-1:0] phase;
    logic                  pc_inc;
    logic                  ir_latch;
    logic                  operand_rd;
    logic                  dest_wr;
  } rsf_seq_t;

  // Whole block state
  typedef struct packed {
    rsf_apb_st_t                             apb_st;
    logic                                    pready;
    logic                                    pslverr;
    logic [31:0]                             prdata;
    logic [RSF_PTR_W-1:0]                    stack_pointer;
    logic                                    stack_full_flag;
    logic                                    stack_underflow_flag;
    logic                                    stack_fault_reset_enable;
    logic [RSF_DEPTH-1:0][RSF_PC_W-1:0]      mem;
    rsf_ctx_t                                shadow;
    rsf_rsp_t                                rsp;
    logic [1:0]                              qcnt;
    logic                                    flush_pend;
    logic                                    exec_valid;
    rsf_seq_t                                seq;
  } rsf_state_t;

endpackage

// [logic/rsf_top.sv]
// Return address stack, stack pointer status, fast context shadows and phase sequencer.
// Assumes an APB master on core_clk and decode logic giving one-cycle requests on core_clk.
`timescale 1ns/1ps

module rsf_top
  import rsf_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rstn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire rsf_cmd_t    cmd,
  output rsf_rsp_t         rsp,
  output rsf_seq_t         seq
);

  rsf_state_t s_ff;
  rsf_state_t nxt_s;
  logic       apb_wr;

  // Entry under the pointer; slot zero has no storage
  function automatic logic [RSF_PC_W-1:0] tos_of(input rsf_state_t st);
    logic [RSF_PC_W-1:0] v;
    v = '0;
    if (st.stack_pointer != RSF_PTR_RST) begin
      v = st.mem[5'(st.stack_pointer - 5'h01)];
    end
    return v;
  endfunction

  // Address decode
  function automatic logic mapped(input logic [7:0] a);
    return (a == RSF_OFS_PTR) || (a == RSF_OFS_TOP_ENTRY_LOW_BYTE) || (a == RSF_OFS_TOP_ENTRY_HIGH_BYTE) ||
           (a == RSF_OFS_TOP_ENTRY_UPPER_BYTE) || (a == RSF_OFS_CTRL);
  endfunction

  // Read data for one register
  function automatic logic [31:0] rd_word(input rsf_state_t st, input logic [7:0] a);
    logic [31:0]         w;
    logic [RSF_PC_W-1:0] t;
    w = '0;
    t = tos_of(st);
    case (a)
      RSF_OFS_PTR: begin
        w[RSF_FULL_BIT] = st.stack_full_flag;
        w[RSF_UNF_BIT]  = st.stack_underflow_flag;
        w[4:0]          = st.stack_pointer;
      end
      RSF_OFS_TOP_ENTRY_LOW_BYTE: w[7:0] = t[7:0];
      RSF_OFS_TOP_ENTRY_HIGH_BYTE: w[7:0] = t[15:8];
      RSF_OFS_TOP_ENTRY_UPPER_BYTE: w[4:0] = t[20:16];
      RSF_OFS_CTRL: w[RSF_FRE_BIT] = st.stack_fault_reset_enable;
      default: w = '0;
    endcase
    return w;
  endfunction

  // Write commits only at the edge where pready is seen high
  assign apb_wr = (s_ff.apb_st == RSF_APB_ANSWER) && psel && penable && pwrite;

  // Next-state logic
  always_comb begin
    logic [RSF_PTR_W-1:0] p;
    logic [RSF_PC_W-1:0]  e;
    p = '0;
    e = '0;
    nxt_s = s_ff;
    nxt_s.rsp.ret_valid   = 1'b0;
    nxt_s.rsp.ctx_valid   = 1'b0;
    nxt_s.rsp.fault_reset = 1'b0;

    // APB slave: answer one cycle into the access phase
    case (s_ff.apb_st)
      RSF_APB_IDLE: begin
        if (psel && penable) begin
          nxt_s.prdata  = pwrite ? 32'h0000_0000 : rd_word(s_ff, paddr);
          nxt_s.pslverr = !mapped(paddr);
          nxt_s.pready  = 1'b1;
          nxt_s.apb_st  = RSF_APB_ANSWER;
        end
      end
      RSF_APB_ANSWER: begin
        nxt_s.pready  = 1'b0;
        nxt_s.pslverr = 1'b0;
        nxt_s.apb_st  = RSF_APB_IDLE;
        if (apb_wr) begin
          e = tos_of(s_ff);
          case (paddr)
            RSF_OFS_PTR: begin
              nxt_s.stack_pointer = pwdata[4:0];
              if (!pwdata[RSF_FULL_BIT]) begin
                nxt_s.stack_full_flag = 1'b0;
              end
              if (!pwdata[RSF_UNF_BIT]) begin
                nxt_s.stack_underflow_flag = 1'b0;
              end
            end
            RSF_OFS_TOP_ENTRY_LOW_BYTE: e[7:0]   = pwdata[7:0];
            RSF_OFS_TOP_ENTRY_HIGH_BYTE: e[15:8]  = pwdata[7:0];
            RSF_OFS_TOP_ENTRY_UPPER_BYTE: e[20:16] = pwdata[4:0];
            RSF_OFS_CTRL: nxt_s.stack_fault_reset_enable = pwdata[RSF_FRE_BIT];
            default: e = e;
          endcase
          if (s_ff.stack_pointer != RSF_PTR_RST) begin
            nxt_s.mem[5'(s_ff.stack_pointer - 5'h01)] = e;
          end
        end
      end
      default: nxt_s.apb_st = RSF_APB_IDLE;
    endcase

    // Stack requests act on the state left by any register write; set wins over clear
    if (cmd.push) begin
      if (nxt_s.stack_pointer == RSF_PTR_TOP) begin
        nxt_s.stack_full_flag = 1'b1;
        if (nxt_s.stack_fault_reset_enable) begin
          nxt_s.rsp.fault_reset = 1'b1;
          nxt_s.stack_pointer   = RSF_PTR_RST;
        end
      end else begin
        p = 5'(nxt_s.stack_pointer + 5'h01);
        nxt_s.mem[5'(p - 5'h01)] = cmd.program_counter;
        nxt_s.stack_pointer = p;
        if (p == RSF_PTR_TOP) begin
          nxt_s.stack_full_flag = 1'b1;
          if (nxt_s.stack_fault_reset_enable) begin
            nxt_s.rsp.fault_reset = 1'b1;
            nxt_s.stack_pointer   = RSF_PTR_RST;
          end
        end
      end
    end else if (cmd.pop_ret || cmd.pop_drop) begin
      nxt_s.rsp.ret_valid = cmd.pop_ret;
      if (nxt_s.stack_pointer == RSF_PTR_RST) begin
        nxt_s.rsp.ret_pc = '0;
        nxt_s.stack_underflow_flag = 1'b1;
        nxt_s.rsp.fault_reset = nxt_s.stack_fault_reset_enable;
      end else begin
        nxt_s.rsp.ret_pc = nxt_s.mem[5'(nxt_s.stack_pointer - 5'h01)];
        nxt_s.stack_pointer = 5'(nxt_s.stack_pointer - 5'h01);
      end
    end

    // Fast context: restore reads the old shadow, save overwrites it
    if (cmd.fast_restore) begin
      nxt_s.rsp.ctx       = s_ff.shadow;
      nxt_s.rsp.ctx_valid = 1'b1;
    end
    if (cmd.fast_save) begin
      nxt_s.shadow = cmd.live;
    end

    // Four-phase sequencer with one-cycle fetch/execute overlap
    nxt_s.qcnt = 2'(s_ff.qcnt + 2'h1);
    if (cmd.pc_change) begin
      nxt_s.flush_pend = 1'b1;
    end
    if (s_ff.qcnt == 2'h3) begin
      nxt_s.exec_valid = !(s_ff.flush_pend || cmd.pc_change);
      nxt_s.flush_pend = 1'b0;
    end
    nxt_s.seq.phase      = 4'(4'h1 << nxt_s.qcnt);
    nxt_s.seq.pc_inc     = (nxt_s.qcnt == 2'h0);
    nxt_s.seq.ir_latch   = (nxt_s.qcnt == 2'h3);
    nxt_s.seq.operand_rd = (nxt_s.qcnt == 2'h1) && nxt_s.exec_valid;
    nxt_s.seq.dest_wr    = (nxt_s.qcnt == 2'h3) && nxt_s.exec_valid;
  end

  // State register
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      s_ff                          <= '0;
      s_ff.apb_st                   <= RSF_APB_IDLE;
      s_ff.stack_pointer            <= RSF_PTR_RST;
      s_ff.stack_full_flag          <= 1'b0;
      s_ff.stack_underflow_flag     <= 1'b0;
      s_ff.stack_fault_reset_enable <= RSF_FRE_RST;
      s_ff.qcnt                     <= RSF_QCNT_RST;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // Outputs straight from the state register
  assign prdata  = s_ff.prdata;
  assign pready  = s_ff.pready;
  assign pslverr = s_ff.pslverr;
  assign rsp     = s_ff.rsp;
  assign seq     = s_ff.seq;

  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  a_push_ptr_step: assert property (cmd.push && !apb_wr && s_ff.stack_pointer < 5'h1E |=>
    s_ff.stack_pointer == 5'($past(s_ff.stack_pointer) + 5'h01) &&
    tos_of(s_ff) == $past(cmd.program_counter))
    else $error("push did not advance pointer and store counter");

  a_pop_ptr_step: assert property ((cmd.pop_ret || cmd.pop_drop) && !cmd.push && !apb_wr &&
    s_ff.stack_pointer != 5'h00 |=> s_ff.stack_pointer == 5'($past(s_ff.stack_pointer) - 5'h01))
    else $error("pop did not decrement pointer");

  a_ptr_read_bits: assert property (pready && psel && !pwrite && paddr == RSF_OFS_PTR |->
    prdata[5] == 1'b0 && prdata[31:8] == 24'h000000)
    else $error("pointer register unimplemented bits not zero");

  a_full_fault_rst: assert property (cmd.push && !apb_wr && s_ff.stack_pointer == 5'h1E &&
    s_ff.stack_fault_reset_enable |=> s_ff.stack_full_flag && rsp.fault_reset &&
    s_ff.stack_pointer == 5'h00)
    else $error("31st push with reset enable mishandled");

  a_full_hold_top: assert property (cmd.push && !apb_wr && s_ff.stack_pointer == 5'h1F &&
    !s_ff.stack_fault_reset_enable |=> s_ff.stack_pointer == 5'h1F &&
    s_ff.mem[30] == $past(s_ff.mem[30]) && !rsp.fault_reset)
    else $error("push beyond full changed the top");

  a_unf_pop_zero: assert property (cmd.pop_ret && !cmd.push && !apb_wr &&
    s_ff.stack_pointer == 5'h00 |=> s_ff.stack_underflow_flag && rsp.ret_valid &&
    rsp.ret_pc == 21'h000000 && s_ff.stack_pointer == 5'h00)
    else $error("underflow pop mishandled");

  a_flag_no_set: assert property ($rose(s_ff.stack_full_flag) |-> $past(cmd.push))
    else $error("full flag set without a push");

  a_fault_gated: assert property (rsp.fault_reset |-> $past(s_ff.stack_fault_reset_enable))
    else $error("fault reset while disabled");

  a_shadow_load: assert property (cmd.fast_save |=> s_ff.shadow == $past(cmd.live))
    else $error("shadow not loaded on save");

  a_fast_restore: assert property (cmd.fast_restore |=> rsp.ctx_valid &&
    rsp.ctx == $past(s_ff.shadow))
    else $error("fast restore gave wrong context");

  a_phase_order: assert property (seq.phase[0] |=> seq.phase[1] ##1 seq.phase[2]
    ##1 seq.phase[3] ##1 seq.phase[0])
    else $error("phase order broken");

  a_phase_strobes: assert property ((seq.pc_inc |-> seq.phase[0]) and
    (seq.ir_latch |-> seq.phase[3]) and (seq.dest_wr |-> seq.phase[3]))
    else $error("strobe in wrong phase");

  a_branch_flush: assert property (cmd.pc_change && s_ff.qcnt == 2'h3 |=>
    seq.phase[0] ##1 (seq.phase[1] && !seq.operand_rd))
    else $error("instruction after branch not flushed");

  // Byte writes to the top entry land in the slot under the pointer
  a_tos_low_write: assert property (apb_wr && paddr == RSF_OFS_TOP_ENTRY_LOW_BYTE &&
    s_ff.stack_pointer != 5'h00 && !cmd.push && !cmd.pop_ret && !cmd.pop_drop |=>
    s_ff.mem[5'($past(s_ff.stack_pointer) - 5'h01)][7:0] == $past(pwdata[7:0]))
    else $error("top entry low byte write lost");

  // Pointer field write takes the five low bits
  a_ptr_field_wr: assert property (apb_wr && paddr == RSF_OFS_PTR &&
    !cmd.push && !cmd.pop_ret && !cmd.pop_drop |=> s_ff.stack_pointer == $past(pwdata[4:0]))
    else $error("pointer field write lost");

  // Full flag stays set until software clears it
  a_full_sticky: assert property (s_ff.stack_full_flag && !apb_wr |=>
    s_ff.stack_full_flag)
    else $error("full flag dropped by itself");

  // Underflow flag stays set until software clears it
  a_unf_sticky: assert property (s_ff.stack_underflow_flag && !apb_wr |=>
    s_ff.stack_underflow_flag)
    else $error("underflow flag dropped by itself");

  // Underflow flag only rises after a pop
  a_unf_no_set: assert property ($rose(s_ff.stack_underflow_flag) |->
    $past(cmd.pop_ret || cmd.pop_drop))
    else $error("underflow flag set without a pop");

  // Shadows keep their value unless a save loads them
  a_shadow_hold: assert property (!cmd.fast_save |=> s_ff.shadow == $past(s_ff.shadow))
    else $error("shadow changed without a save");

  // Restore alone leaves the single shadow level in place
  a_restore_keep: assert property (cmd.fast_restore && !cmd.fast_save |=>
    s_ff.shadow == $past(s_ff.shadow))
    else $error("restore disturbed the shadow");

  // A second save replaces the first; no older copy survives
  a_nested_save: assert property (cmd.fast_save ##1 cmd.fast_save |=>
    s_ff.shadow == $past(cmd.live))
    else $error("nested save kept an old shadow");

  // Phase clocks are one-hot once running
  a_phase_onehot: assert property (seq.phase != 4'h0 |-> $onehot(seq.phase))
    else $error("phase clocks overlap");

  // Counter step and latch come with every phase one and four
  a_strobe_every: assert property ((seq.phase[0] |-> seq.pc_inc) and
    (seq.phase[3] |-> seq.ir_latch))
    else $error("phase strobe missing");

  // Operand read only in phase two
  a_operand_phase: assert property (seq.operand_rd |-> seq.phase[1])
    else $error("operand read outside phase two");

  // An executing instruction reads, then writes two clocks later in the same instruction cycle
  a_exec_pair: assert property (seq.operand_rd |-> ##2 seq.dest_wr)
    else $error("executed instruction lost its write");

endmodule

// [bench/rsf_core_model.sv]
// Decode and execute side model: issues one-cycle stack and context requests.
// Assumes rsp answers at the edge that takes a request, one cycle after the request is raised.
`timescale 1ns/1ps

module rsf_core_model
  import rsf_pkg::*;
(
  input  wire logic     core_clk,
  output rsf_cmd_t      cmd,
  input  wire rsf_rsp_t rsp
);
  // Idle until a request is made
  initial cmd = '0;

  // Raise a request for one cycle, then capture the answer after it lands
  task automatic issue(input rsf_cmd_t c, output rsf_rsp_t r);
    @(posedge core_clk);
    cmd <= c;
    @(posedge core_clk);
    cmd <= '0;
    #1 r = rsp;
  endtask
endmodule

// [bench/rsf_top_tb.sv]
// Self-checking bench for rsf_top: APB register tasks plus decode requests through the core model.
// Assumes APB answers in the second access cycle and rsp one cycle after a request.
`timescale 1ns/1ps

module rsf_top_tb
  import rsf_pkg::*;
;
  localparam logic [4:0] PUSH = 5'h10;
  localparam logic [4:0] POPR = 5'h08;
  localparam logic [4:0] DROP = 5'h04;
  localparam logic [4:0] SAVE = 5'h02;
  localparam logic [4:0] REST = 5'h01;

  logic        core_clk;
  logic        rstn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic        pready;
  logic        pslverr;
  logic        err;
  logic [3:0]  ph;
  rsf_cmd_t    cmd;
  rsf_cmd_t    c;
  rsf_rsp_t    rsp;
  rsf_rsp_t    r;
  rsf_seq_t    seq;
  int          error_cnt;
  int          num_checks;
  int          cyc;

  rsf_top u_dut (.core_clk(core_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cmd(cmd), .rsp(rsp), .seq(seq));

  rsf_core_model u_core (.core_clk(core_clk), .cmd(cmd), .rsp(rsp));

  // 250 MHz clock
  always #2 core_clk = ~core_clk;

  // Compare one value and count it
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // One APB transfer; holds the request until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    // Ends when pready is seen high; only the bench timeout ends a hang
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0);
    chk(rd, exp, what);
  endtask

  // Decode request: push, pop_ret, pop_drop, fast_save, fast_restore
  task automatic op(input logic [4:0] k, input logic [20:0] pc, input rsf_ctx_t lv);
    c = '0;
    {c.push, c.pop_ret, c.pop_drop, c.fast_save, c.fast_restore} = k;
    c.program_counter = pc;
    c.live = lv;
    u_core.issue(c, r);
  endtask

  task automatic wrap_up();
    $display("Checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Cut a hang short
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      $display("[ERR] %0t timeout", $time);
      wrap_up();
    end
  end

  // Main sequence
  initial begin
    core_clk = 0; rstn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    error_cnt = 0; num_checks = 0; cyc = 0;
    repeat (16) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    #1 ph = 4'h1;
    for (int i = 0; i < 8; i++) begin
      chk(seq.phase, ph, "phase");
      chk(seq.pc_inc, ph[0], "pc_inc");
      chk(seq.ir_latch, ph[3], "ir_latch");
      ph = {ph[2:0], ph[3]};
      @(posedge core_clk);
      #1;
    end
    $display("Test sequencer done");
    rd_chk(RSF_OFS_PTR, 32'h0, "ptr reset");
    rd_chk(RSF_OFS_CTRL, 32'h1, "ctrl reset");
    apb(1'b0, 8'h14, 32'h0);
    chk(err, 1'b1, "unmapped err");
    chk(rd, 32'h0, "unmapped data");
    $display("Test reset values done");
    op(PUSH, 21'h1ABCDE, '0);
    op(PUSH, 21'h000200, '0);
    op(DROP, 21'h0, '0);
    rd_chk(RSF_OFS_PTR, 32'h1, "ptr after drop");
    rd_chk(RSF_OFS_TOP_ENTRY_LOW_BYTE, 32'hDE, "top low");
    rd_chk(RSF_OFS_TOP_ENTRY_HIGH_BYTE, 32'hBC, "top high");
    rd_chk(RSF_OFS_TOP_ENTRY_UPPER_BYTE, 32'h1A, "top upper");
    apb(1'b1, RSF_OFS_TOP_ENTRY_LOW_BYTE, 32'h55);
    apb(1'b1, RSF_OFS_TOP_ENTRY_HIGH_BYTE, 32'h66);
    apb(1'b1, RSF_OFS_TOP_ENTRY_UPPER_BYTE, 32'h07);
    op(POPR, 21'h0, '0);
    chk(r.ret_valid, 1'b1, "ret valid");
    chk(r.ret_pc, 21'h076655, "ret pc");
    rd_chk(RSF_OFS_PTR, 32'h0, "ptr after pop");
    $display("Test push pop done");
    apb(1'b1, RSF_OFS_PTR, 32'hFF);
    rd_chk(RSF_OFS_PTR, 32'h1F, "ptr field");
    apb(1'b1, RSF_OFS_CTRL, 32'h0);
    apb(1'b1, RSF_OFS_PTR, 32'h1E);
    op(PUSH, 21'h0AAAAA, '0);
    chk(r.fault_reset, 1'b0, "no reset full");
    rd_chk(RSF_OFS_PTR, 32'h9F, "full flag");
    op(PUSH, 21'h155555, '0);
    rd_chk(RSF_OFS_PTR, 32'h9F, "ptr held");
    rd_chk(RSF_OFS_TOP_ENTRY_LOW_BYTE, 32'hAA, "no overwrite");
    apb(1'b1, RSF_OFS_PTR, 32'h00);
    op(POPR, 21'h0, '0);
    chk(r.ret_pc, 21'h0, "underflow pc");
    chk(r.fault_reset, 1'b0, "no reset unf");
    rd_chk(RSF_OFS_PTR, 32'h40, "underflow flag");
    apb(1'b1, RSF_OFS_CTRL, 32'h1);
    op(POPR, 21'h0, '0);
    chk(r.fault_reset, 1'b1, "reset unf");
    apb(1'b1, RSF_OFS_PTR, 32'h80);
    rd_chk(RSF_OFS_PTR, 32'h00, "clear only");
    apb(1'b1, RSF_OFS_PTR, 32'h1E);
    op(PUSH, 21'h012345, '0);
    chk(r.fault_reset, 1'b1, "reset full");
    rd_chk(RSF_OFS_PTR, 32'h80, "full then reset");
    $display("Test faults done");
    op(SAVE, 21'h0, 20'hA53C9);
    op(REST, 21'h0, '0);
    chk(r.ctx_valid, 1'b1, "ctx valid");
    chk(r.ctx, 20'hA53C9, "ctx first");
    op(SAVE, 21'h0, 20'h5AC36);
    op(REST, 21'h0, '0);
    chk(r.ctx, 20'h5AC36, "ctx overwritten");
    op(REST, 21'h0, '0);
    chk(r.ctx, 20'h5AC36, "ctx one level");
    $display("Test fast context done");
    // Counter change taken in phase four flushes the next instruction cycle
    do @(posedge core_clk); while (seq.phase !== 4'h2);
    c = '0;
    c.pc_change = 1'b1;
    u_core.issue(c, r);
    for (int i = 0; i < 4; i++) begin
      chk(seq.operand_rd, 1'b0, "flushed read");
      chk(seq.dest_wr, 1'b0, "flushed write");
      @(posedge core_clk);
      #1;
    end
    @(posedge core_clk);
    #1;
    chk(seq.operand_rd, 1'b1, "operand read");
    @(posedge core_clk);
    @(posedge core_clk);
    #1;
    chk(seq.dest_wr, 1'b1, "dest write");
    $display("Test branch flush done");
    wrap_up();
  end
endmodule
